// [bench/scv_decoder_asserts.sv]
// Checker for the command decoder: status words, compare stream, start.
// Assumes it is bound to scv_decoder and sees only its ports.
`timescale 1ns/1ps
module scv_decoder_asserts (
  input logic        clk,
  input logic        rstn,
  input logic        cdb_ready,
  input logic        xfer_start,
  input logic [1:0]  xfer_mode,
  input logic [31:0] xfer_count,
  input logic        cmp_valid,
  input logic        cmp_ready,
  input logic [7:0]  cmp_src,
  input logic [7:0]  cmp_dst,
  input logic        med_done,
  input logic        med_err,
  input logic        st_valid,
  input logic        st_ready,
  input logic [7:0]  st_status,
  input logic [3:0]  st_sense,
  input logic [2:0]  st_class
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic take;
  assign take = cmp_valid && cmp_ready;
  // ====
  // Properties
  property p_start;
    xfer_start |=> !xfer_start && !cdb_ready;
  endproperty
  a_start: assert property (p_start)
    else $error("start pulse too long");
  property p_dec;
    take && cmp_src == cmp_dst |=> xfer_count == $past(xfer_count) - 32'h1;
  endproperty
  a_dec: assert property (p_dec)
    else $error("count not stepped");
  property p_stop;
    take && cmp_src != cmp_dst |=> !cmp_ready;
  endproperty
  a_stop: assert property (p_stop)
    else $error("pairs taken after mismatch");
  property p_mis;
    take && cmp_src != cmp_dst |-> ##[1:4]
      (st_valid && st_status == 8'h02 && st_sense == 4'he);
  endproperty
  a_mis: assert property (p_mis)
    else $error("mismatch status wrong");
  property p_med;
    med_done && med_err && xfer_mode == 2'h2 |-> ##[1:4]
      (st_valid && st_status == 8'h02 && st_sense == 4'h3);
  endproperty
  a_med: assert property (p_med)
    else $error("medium failure status wrong");
  property p_nopair;
    cmp_ready |-> xfer_mode != 2'h2;
  endproperty
  a_nopair: assert property (p_nopair)
    else $error("pairs taken in medium mode");
  // A stalled reader must see the same word until it takes it.
  property p_hold;
    st_valid && !st_ready |=> st_valid && $stable(st_status)
      && $stable(st_sense) && $stable(st_class);
  endproperty
  a_hold: assert property (p_hold)
    else $error("status word changed while stalled");
  property p_rsv;
    st_valid && st_class == 3'h2 |-> st_status == 8'h02 && st_sense == 4'h5;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved code status wrong");
  property p_vnd;
    st_valid && st_class == 3'h3 |-> st_status == 8'h02 && st_sense == 4'h5;
  endproperty
  a_vnd: assert property (p_vnd)
    else $error("vendor code status wrong");
  property p_good;
    st_valid && st_status == 8'h00 |-> st_sense == 4'h0 && st_class == 3'h0;
  endproperty
  a_good: assert property (p_good)
    else $error("good status with sense or class");
  c_byte: cover property (xfer_start && xfer_mode == 2'h1);
  c_mis: cover property (st_valid && st_sense == 4'he);
  c_stall: cover property (st_valid && !st_ready ##1 st_valid && !st_ready);
endmodule
bind scv_decoder scv_decoder_asserts u_chk (.clk(clk), .rstn(rstn),
  .cdb_ready(cdb_ready), .xfer_start(xfer_start), .xfer_mode(xfer_mode),
  .xfer_count(xfer_count), .cmp_valid(cmp_valid), .cmp_ready(cmp_ready),
  .cmp_src(cmp_src), .cmp_dst(cmp_dst), .med_done(med_done),
  .med_err(med_err), .st_valid(st_valid), .st_ready(st_ready),
  .st_status(st_status), .st_sense(st_sense), .st_class(st_class));

// [bench/scv_decoder_tb.sv]
// Self-checking bench for the group-one command decoder.
// Assumes scv_init plays the initiator; the bench is data engine and reader.
`timescale 1ns/1ps
`include "scv_defines.vh"
module scv_decoder_tb;
  logic        clk, rstn, cmp_valid, med_done, med_err, st_ready;
  logic [4:0]  dev_type;
  logic [7:0]  cmp_src, cmp_dst;
  wire         cdb_valid, cdb_ready, prm_valid, prm_ready, xfer_start;
  wire         cmp_ready, st_valid;
  wire  [7:0]  cdb_data, prm_data, src_unit, dst_unit, st_status;
  wire  [1:0]  xfer_mode;
  wire  [31:0] xfer_count;
  wire  [3:0]  st_sense;
  wire  [2:0]  st_class;
  int          errors, n_checks;
  scv_decoder #(.G1_TYPE_MASK(32'hfffffffe)) dut (.clk(clk), .rstn(rstn),
    .dev_type(dev_type), .cdb_valid(cdb_valid), .cdb_ready(cdb_ready),
    .cdb_data(cdb_data), .prm_valid(prm_valid), .prm_ready(prm_ready),
    .prm_data(prm_data), .xfer_start(xfer_start), .xfer_mode(xfer_mode),
    .src_unit(src_unit), .dst_unit(dst_unit), .xfer_count(xfer_count),
    .cmp_valid(cmp_valid), .cmp_ready(cmp_ready), .cmp_src(cmp_src),
    .cmp_dst(cmp_dst), .med_done(med_done), .med_err(med_err),
    .st_valid(st_valid), .st_ready(st_ready), .st_status(st_status),
    .st_sense(st_sense), .st_class(st_class));
  scv_init ini (.clk(clk), .cdb_ready(cdb_ready), .prm_ready(prm_ready),
    .cdb_valid(cdb_valid), .cdb_data(cdb_data), .prm_valid(prm_valid),
    .prm_data(prm_data));
  // ====
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Reader stalls a few cycles so the buffer must hold the word.
  task automatic get_st(input logic [7:0] s, input logic [3:0] k,
                        input logic [2:0] c);
    int t = 0;
    repeat (3) @(posedge clk);
    st_ready <= 1'b1;
    do begin @(negedge clk); t++; end while (st_valid !== 1'b1 && t < 200);
    chk("st_valid", st_valid, 1'b1);
    chk("st_status", st_status, s);
    chk("st_sense", st_sense, k);
    chk("st_class", st_class, c);
    @(posedge clk);
    st_ready <= 1'b0;
  endtask
  task automatic start(input logic [7:0] op, b1, s, d,
                       input logic [31:0] c, input logic [1:0] m);
    int t = 0;
    ini.send_cmd(op, b1, 24'd10);
    ini.send_list(s, d, c);
    do begin @(negedge clk); t++; end while (xfer_start !== 1'b1 && t < 20);
    chk("xfer_start", xfer_start, 1'b1);
    chk("xfer_mode", xfer_mode, m);
    chk("src_unit", src_unit, s);
    chk("dst_unit", dst_unit, d);
    chk("xfer_count", xfer_count, c);
  endtask
  task automatic pairs(input int n, bad);
    int t;
    // Pairs are offered on a rising edge, never mid-cycle.
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      cmp_valid <= 1'b1;
      cmp_src   <= 8'h30 + i[7:0];
      cmp_dst   <= (i == bad) ? 8'hc5 : 8'h30 + i[7:0];
      t = 0;
      do begin @(negedge clk); t++; end while (cmp_ready !== 1'b1 && t < 50);
      chk("cmp_ready", cmp_ready, 1'b1);
      @(posedge clk);
    end
    cmp_valid <= 1'b0;
    cmp_src   <= 8'ha5;
  endtask
  // ====
  // Scenarios
  task automatic t_compare;
    start(`SCV_OP_COMPARE, 8'h20, 8'h01, 8'h02, 32'd3, 2'h0);
    pairs(3, -1);
    get_st(8'h00, 4'h0, 3'h0);
    start(`SCV_OP_COMPARE, 8'h00, 8'h03, 8'h03, 32'd0, 2'h0);
    get_st(8'h00, 4'h0, 3'h0);
    start(`SCV_OP_COMPARE, 8'h00, 8'h04, 8'h05, 32'd4, 2'h0);
    pairs(2, 1);
    repeat (2) @(negedge clk);
    chk("cmp_ready", cmp_ready, 1'b0);
    get_st(8'h02, 4'he, 3'h0);
  endtask
  task automatic t_verify;
    start(`SCV_OP_COPY_VERIFY, 8'h02, 8'h06, 8'h07, 32'd2, 2'h1);
    pairs(2, 1);
    get_st(8'h02, 4'he, 3'h0);
    for (int e = 0; e < 2; e++) begin
      start(`SCV_OP_COPY_VERIFY, 8'h00, 8'h08, 8'h09, 32'd5, 2'h2);
      repeat (3) @(posedge clk);
      med_done <= 1'b1;
      med_err  <= e[0];
      @(posedge clk);
      med_done <= 1'b0;
      get_st(e ? 8'h02 : 8'h00, e ? 4'h3 : 4'h0, 3'h0);
    end
  endtask
  task automatic t_classes;
    logic [7:0] op [14] = '{8'h40, 8'h5f, 8'h60, 8'h7f, 8'h80, 8'h9f,
      8'ha0, 8'haf, 8'hb0, 8'hbf, 8'hc0, 8'hdf, 8'he0, 8'hff};
    logic [2:0] c;
    ini.gap = 1;
    foreach (op[i]) begin
      ini.send_cmd(op[i], 8'h00, 24'd0);
      c = (op[i][7:6] == 2'h3 || op[i][7:4] == 4'ha) ? 3'h3 : 3'h2;
      get_st(8'h02, 4'h5, c);
    end
    ini.gap = 0;
  endtask
  task automatic t_misc;
    dev_type <= 5'h00;
    @(posedge clk);
    ini.send_cmd(`SCV_OP_COMPARE, 8'h00, 24'd10);
    get_st(8'h02, 4'h5, 3'h1);
    dev_type <= 5'h01;
    ini.send_cmd(`SCV_OP_COMPARE, 8'h00, 24'd4);
    get_st(8'h02, 4'h5, 3'h5);
    ini.send_cmd(8'ha3, 8'h00, 24'd0);
    @(posedge clk);
    ini.send_cmd(8'hb7, 8'h00, 24'd0);
    get_st(8'h02, 4'h5, 3'h3);
    get_st(8'h02, 4'h5, 3'h2);
    // Codes of other groups and other group-one codes are refused too.
    ini.send_cmd(8'h12, 8'h00, 24'd0);
    get_st(8'h02, 4'h5, 3'h4);
    ini.send_cmd(8'h2a, 8'h00, 24'd10);
    get_st(8'h02, 4'h5, 3'h1);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rstn      = 1'b0;
    dev_type  = 5'h01;
    cmp_valid = 1'b0;
    cmp_src   = 8'h00;
    cmp_dst   = 8'h00;
    med_done  = 1'b0;
    med_err   = 1'b0;
    st_ready  = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_compare;
    t_verify;
    t_classes;
    t_misc;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict;
  end
endmodule

// [bench/scv_init.sv]
// Initiator model: offers command blocks and parameter lists.
// Assumes ready is a flop on clk, so its negedge value is what counts.
`timescale 1ns/1ps
module scv_init (
  input  logic       clk,
  input  logic       cdb_ready,
  input  logic       prm_ready,
  output logic       cdb_valid,
  output logic [7:0] cdb_data,
  output logic       prm_valid,
  output logic [7:0] prm_data
);
  int gap = 0;
  initial begin
    cdb_valid = 1'b0;
    cdb_data  = 8'h00;
    prm_valid = 1'b0;
    prm_data  = 8'h00;
  end
  // Released lines show the inverse byte so no stale copy can match.
  task automatic idle(input bit p, input logic [7:0] b);
    if (p) begin
      prm_valid <= 1'b0;
      prm_data  <= ~b;
    end else begin
      cdb_valid <= 1'b0;
      cdb_data  <= ~b;
    end
  endtask
  task automatic put(input bit p, input logic [7:0] b);
    if (p) begin
      prm_valid <= 1'b1;
      prm_data  <= b;
    end else begin
      cdb_valid <= 1'b1;
      cdb_data  <= b;
    end
    do @(negedge clk); while (!(p ? prm_ready : cdb_ready));
    @(posedge clk);
    if (gap > 0) begin
      idle(p, b);
      repeat (gap) @(posedge clk);
    end
  endtask
  task automatic send_cmd(input logic [7:0] op, b1, input logic [23:0] n);
    logic [95:0] w;
    int k;
    w = {op, b1, 8'h00, n, 48'h0};
    k = (op[7:5] == 3'h1 || op[7:5] == 3'h2) ? 10 : op[7:5] == 3'h5 ? 12 : 6;
    for (int i = 0; i < k; i++) put(1'b0, w[95-8*i -: 8]);
    if (gap == 0) idle(1'b0, w[95-8*(k-1) -: 8]);
  endtask
  task automatic send_list(input logic [7:0] s, d, input logic [31:0] c);
    logic [79:0] w;
    w = {32'h5a5a5a5a, s, d, c};
    for (int i = 9; i >= 0; i--) put(1'b1, w[i*8 +: 8]);
    if (gap == 0) idle(1'b1, w[7:0]);
  endtask
endmodule

// [core/scv_decoder.v]
// Group-one command decoder for compare and copy-and-verify.
// Assumes command, parameter and comparison streams come from logic
// on clk; a data engine outside moves the blocks and feeds byte pairs.
`timescale 1ns/1ps
`include "scv_defines.vh"
module scv_decoder #(
  parameter G1_TYPE_MASK = 32'hffffffff
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire [4:0]  dev_type,
  input  wire        cdb_valid,
  output reg         cdb_ready,
  input  wire [7:0]  cdb_data,
  input  wire        prm_valid,
  output reg         prm_ready,
  input  wire [7:0]  prm_data,
  output reg         xfer_start,
  output reg  [1:0]  xfer_mode,
  output reg  [7:0]  src_unit,
  output reg  [7:0]  dst_unit,
  output reg  [31:0] xfer_count,
  input  wire        cmp_valid,
  output reg         cmp_ready,
  input  wire [7:0]  cmp_src,
  input  wire [7:0]  cmp_dst,
  input  wire        med_done,
  input  wire        med_err,
  output wire        st_valid,
  input  wire        st_ready,
  output wire [7:0]  st_status,
  output wire [3:0]  st_sense,
  output wire [2:0]  st_class
);

  // ==========================================================
  // States
  // ==========================================================
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_DEC   = 7'h02;
  localparam [6:0] S_PRM   = 7'h04;
  localparam [6:0] S_START = 7'h08;
  localparam [6:0] S_CMP   = 7'h10;
  localparam [6:0] S_MED   = 7'h20;
  localparam [6:0] S_DONE  = 7'h40;

  reg  [6:0]  state_reg;
  reg  [6:0]  state_next;
  reg  [3:0]  cdb_idx_reg;
  reg  [7:0]  op_reg;
  reg         bytchk_reg;
  reg  [23:0] plen_reg;
  reg  [23:0] prm_idx_reg;
  reg  [7:0]  status_reg;
  reg  [3:0]  sense_reg;
  reg  [2:0]  class_reg;
  wire        cdb_fire;
  wire        prm_fire;
  wire        cmp_fire;
  wire        fifo_ready;
  wire        g1_ok;
  wire [2:0]  op_cls;
  wire        prm_last;

  // ==========================================================
  // Functions
  // ==========================================================
  function in_range;
    input [7:0] op;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_range = (op >= lo) && (op <= hi);
    end
  endfunction

  // Command block length by group; group one is ten bytes.
  function [3:0] cdb_len;
    input [7:0] op;
    begin
      case (op[7:5])
        3'h1:    cdb_len = `SCV_CDB_LEN_G1;
        3'h2:    cdb_len = `SCV_CDB_LEN_G1;
        3'h5:    cdb_len = `SCV_CDB_LEN_G5;
        default: cdb_len = `SCV_CDB_LEN_G0;
      endcase
    end
  endfunction

  function [2:0] classify;
    input [7:0] op;
    input       type_ok;
    begin
      if (((op == `SCV_OP_COMPARE) || (op == `SCV_OP_COPY_VERIFY))
          && type_ok) begin
        classify = `SCV_CLS_DONE;
      end else if (in_range(op, `SCV_G2_LO, `SCV_G2_HI)) begin
        classify = `SCV_CLS_RESERVED;
      end else if (in_range(op, `SCV_G3_LO, `SCV_G3_HI)) begin
        classify = `SCV_CLS_RESERVED;
      end else if (in_range(op, `SCV_G4_LO, `SCV_G4_HI)) begin
        classify = `SCV_CLS_RESERVED;
      end else if (in_range(op, `SCV_G5V_LO, `SCV_G5V_HI)) begin
        classify = `SCV_CLS_VENDOR;
      end else if (in_range(op, `SCV_G5R_LO, `SCV_G5R_HI)) begin
        classify = `SCV_CLS_RESERVED;
      end else if (in_range(op, `SCV_G6_LO, `SCV_G6_HI)) begin
        classify = `SCV_CLS_VENDOR;
      end else if (in_range(op, `SCV_G7_LO, `SCV_G7_HI)) begin
        classify = `SCV_CLS_VENDOR;
      end else if (op[7:5] == 3'h1) begin
        classify = `SCV_CLS_G1_OTHER;
      end else begin
        classify = `SCV_CLS_ELSEWHERE;
      end
    end
  endfunction

  // ==========================================================
  // Handshakes and decode
  // ==========================================================
  assign cdb_fire = cdb_valid & cdb_ready;
  assign prm_fire = prm_valid & prm_ready;
  assign cmp_fire = cmp_valid & cmp_ready;
  assign g1_ok    = G1_TYPE_MASK[dev_type];
  assign op_cls   = classify(op_reg, g1_ok);
  assign prm_last = (prm_idx_reg == plen_reg - 24'h000001);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (cdb_fire && (cdb_idx_reg != 4'h0) &&
            (cdb_idx_reg == cdb_len(op_reg) - 4'h1)) begin
          state_next = S_DEC;
        end else if (cdb_fire && (cdb_idx_reg == 4'h0) &&
                     (cdb_len(cdb_data) == 4'h1)) begin
          state_next = S_DEC;
        end
      end
      S_DEC: begin
        if (op_cls != `SCV_CLS_DONE) begin
          state_next = S_DONE;
        end else if (plen_reg < `SCV_PRM_MIN) begin
          state_next = S_DONE;
        end else begin
          state_next = S_PRM;
        end
      end
      S_PRM: begin
        if (prm_fire && prm_last) begin
          state_next = S_START;
        end
      end
      S_START: begin
        if (xfer_count == 32'h0) begin
          state_next = S_DONE;
        end else if (xfer_mode == `SCV_MODE_VFY_MED) begin
          state_next = S_MED;
        end else begin
          state_next = S_CMP;
        end
      end
      S_CMP: begin
        if (cmp_fire && ((cmp_src != cmp_dst) ||
                         (xfer_count == 32'h1))) begin
          state_next = S_DONE;
        end
      end
      S_MED: begin
        if (med_done) begin
          state_next = S_DONE;
        end
      end
      S_DONE: begin
        // The status slot stalls here; no command is taken meanwhile.
        if (fifo_ready) begin
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // ==========================================================
  // Datapath
  // ==========================================================
  always @(posedge clk) begin
    if (!rstn) begin
      state_reg   <= S_IDLE;
      cdb_idx_reg <= 4'h0;
      op_reg      <= 8'h00;
      bytchk_reg  <= 1'b0;
      plen_reg    <= 24'h0;
      prm_idx_reg <= 24'h0;
      status_reg  <= `SCV_ST_GOOD;
      sense_reg   <= `SCV_SK_NONE;
      class_reg   <= `SCV_CLS_DONE;
      cdb_ready   <= 1'b0;
      prm_ready   <= 1'b0;
      cmp_ready   <= 1'b0;
      xfer_start  <= 1'b0;
      xfer_mode   <= `SCV_MODE_COMPARE;
      src_unit    <= 8'h00;
      dst_unit    <= 8'h00;
      xfer_count  <= 32'h0;
    end else begin
      state_reg  <= state_next;
      cdb_ready  <= (state_next == S_IDLE);
      prm_ready  <= (state_next == S_PRM);
      cmp_ready  <= (state_next == S_CMP);
      xfer_start <= (state_next == S_START);
      case (state_reg)
        S_IDLE: begin
          if (cdb_fire) begin
            cdb_idx_reg <= cdb_idx_reg + 4'h1;
            case (cdb_idx_reg)
              `SCV_CDB_OP:      op_reg <= cdb_data;
              `SCV_CDB_LUN:     bytchk_reg <= cdb_data[`SCV_BYTCHK_BIT];
              `SCV_CDB_LEN_MSB: plen_reg[23:16] <= cdb_data;
              `SCV_CDB_LEN_MID: plen_reg[15:8] <= cdb_data;
              `SCV_CDB_LEN_LSB: plen_reg[7:0] <= cdb_data;
              default:          cdb_idx_reg <= cdb_idx_reg + 4'h1;
            endcase
          end
        end
        S_DEC: begin
          cdb_idx_reg <= 4'h0;
          prm_idx_reg <= 24'h0;
          class_reg   <= op_cls;
          status_reg  <= `SCV_ST_GOOD;
          sense_reg   <= `SCV_SK_NONE;
          if (op_cls != `SCV_CLS_DONE) begin
            status_reg <= `SCV_ST_CHECK;
            sense_reg  <= `SCV_SK_ILLEGAL;
          end else if (plen_reg < `SCV_PRM_MIN) begin
            // A list too short to name units and a count is refused.
            class_reg  <= `SCV_CLS_BADLIST;
            status_reg <= `SCV_ST_CHECK;
            sense_reg  <= `SCV_SK_ILLEGAL;
          end
          if (op_reg == `SCV_OP_COMPARE) begin
            xfer_mode <= `SCV_MODE_COMPARE;
          end else if (bytchk_reg) begin
            xfer_mode <= `SCV_MODE_VFY_BYTE;
          end else begin
            xfer_mode <= `SCV_MODE_VFY_MED;
          end
        end
        S_PRM: begin
          if (prm_fire) begin
            prm_idx_reg <= prm_idx_reg + 24'h000001;
            if (prm_idx_reg == `SCV_PRM_SRC) begin
              src_unit <= prm_data;
            end
            if (prm_idx_reg == `SCV_PRM_DST) begin
              dst_unit <= prm_data;
            end
            if ((prm_idx_reg >= `SCV_PRM_CNT0) &&
                (prm_idx_reg <= `SCV_PRM_CNT3)) begin
              xfer_count <= {xfer_count[23:0], prm_data};
            end
          end
        end
        S_CMP: begin
          if (cmp_fire) begin
            xfer_count <= xfer_count - 32'h1;
            if (cmp_src != cmp_dst) begin
              status_reg <= `SCV_ST_CHECK;
              sense_reg  <= `SCV_SK_MISCOMPARE;
            end
          end
        end
        S_MED: begin
          // A failed medium check is a medium error, not a miscompare.
          if (med_done && med_err) begin
            status_reg <= `SCV_ST_CHECK;
            sense_reg  <= `SCV_SK_MEDIUM;
          end
        end
        default: begin
          cdb_idx_reg <= cdb_idx_reg;
        end
      endcase
    end
  end

  // ==========================================================
  // Status buffer
  // ==========================================================
  scv_skid #(
    .WIDTH (15)
  ) u_status (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (state_reg == S_DONE),
    .in_ready  (fifo_ready),
    .in_data   ({class_reg, sense_reg, status_reg}),
    .out_valid (st_valid),
    .out_ready (st_ready),
    .out_data  ({st_class, st_sense, st_status})
  );

endmodule

// [core/scv_defines.vh]
// Constants for the group-one command decoder: opcodes, ranges,
// command block layout, parameter list layout, status and sense codes.
// Assumes it is included by bare name from the core files.
//
// What this block does
// - Opcode 39h compares source against destination bytes.
// - Compare parameter list uses the copy format.
// - Unit identities and count come from list.
// - Compare mismatch gives CHECK CONDITION, MISCOMPARE.
// - Opcode 3Ah copies then verifies destination.
// - Byte check clear means medium check only.
// - Byte check set compares written against source.
// - Verify mismatch gives CHECK CONDITION, MISCOMPARE.
// - Opcodes 40h to 5Fh are reserved.
// - Opcodes 60h to 7Fh are reserved.
// - Opcodes 80h to 9Fh are reserved.
// - A0h-AFh vendor unique, B0h-BFh reserved.
// - Opcodes C0h to DFh are vendor unique.
// - Opcodes E0h to FFh are vendor unique.
// - Group-one meaning depends on device type.
`ifndef SCV_DEFINES_VH
`define SCV_DEFINES_VH

// ==========================================================
// Operation codes and group boundaries
// ==========================================================
`define SCV_OP_COMPARE      8'h39
`define SCV_OP_COPY_VERIFY  8'h3a
`define SCV_G2_LO           8'h40
`define SCV_G2_HI           8'h5f
`define SCV_G3_LO           8'h60
`define SCV_G3_HI           8'h7f
`define SCV_G4_LO           8'h80
`define SCV_G4_HI           8'h9f
`define SCV_G5V_LO          8'ha0
`define SCV_G5V_HI          8'haf
`define SCV_G5R_LO          8'hb0
`define SCV_G5R_HI          8'hbf
`define SCV_G6_LO           8'hc0
`define SCV_G6_HI           8'hdf
`define SCV_G7_LO           8'he0
`define SCV_G7_HI           8'hff

// ==========================================================
// Command block layout
// ==========================================================
`define SCV_CDB_LEN_G0      4'h6
`define SCV_CDB_LEN_G1      4'ha
`define SCV_CDB_LEN_G5      4'hc
`define SCV_CDB_OP          4'h0
`define SCV_CDB_LUN         4'h1
`define SCV_CDB_LEN_MSB     4'h3
`define SCV_CDB_LEN_MID     4'h4
`define SCV_CDB_LEN_LSB     4'h5
`define SCV_BYTCHK_BIT      1
`define SCV_LUN_MSB         7
`define SCV_LUN_LSB         5

// ==========================================================
// Parameter list layout
// ==========================================================
`define SCV_PRM_SRC         24'h000004
`define SCV_PRM_DST         24'h000005
`define SCV_PRM_CNT0        24'h000006
`define SCV_PRM_CNT3        24'h000009
`define SCV_PRM_MIN         24'h00000a

// ==========================================================
// Status, sense keys and opcode classes
// ==========================================================
`define SCV_ST_GOOD         8'h00
`define SCV_ST_CHECK        8'h02
`define SCV_SK_NONE         4'h0
`define SCV_SK_MEDIUM       4'h3
`define SCV_SK_ILLEGAL      4'h5
`define SCV_SK_MISCOMPARE   4'he
`define SCV_CLS_DONE        3'h0
`define SCV_CLS_G1_OTHER    3'h1
`define SCV_CLS_RESERVED    3'h2
`define SCV_CLS_VENDOR      3'h3
`define SCV_CLS_ELSEWHERE   3'h4
`define SCV_CLS_BADLIST     3'h5
`define SCV_MODE_COMPARE    2'h0
`define SCV_MODE_VFY_BYTE   2'h1
`define SCV_MODE_VFY_MED    2'h2

`endif

// [core/scv_skid.v]
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on clk; all outputs come from flip-flops.
`timescale 1ns/1ps
module scv_skid #(
  parameter WIDTH = 15
) (
  input  wire             clk,
  input  wire             rstn,
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg  [WIDTH-1:0] skid_data_reg;
  reg              skid_valid_reg;
  wire             in_fire;
  wire             load;
  wire             skid_next;

  // ==========================================================
  // Second slot catches a word when the output is stalled.
  // ==========================================================
  assign in_fire   = in_valid & in_ready;
  assign load      = ~out_valid | out_ready;
  assign skid_next = load ? 1'b0 : (skid_valid_reg | in_fire);

  always @(posedge clk) begin
    if (!rstn) begin
      out_valid      <= 1'b0;
      out_data       <= {WIDTH{1'b0}};
      skid_valid_reg <= 1'b0;
      skid_data_reg  <= {WIDTH{1'b0}};
      in_ready       <= 1'b0;
    end else begin
      in_ready       <= ~skid_next;
      skid_valid_reg <= skid_next;
      if (load) begin
        if (skid_valid_reg) begin
          out_valid <= 1'b1;
          out_data  <= skid_data_reg;
        end else begin
          out_valid <= in_fire;
          if (in_fire) begin
            out_data <= in_data;
          end
        end
      end else if (in_fire) begin
        skid_data_reg <= in_data;
      end
    end
  end

endmodule
